// ==== rtl/pwri_pkg.sv ====
// package for the pwm register interface: offsets, fields, resets, timing
// assumes a 32-bit apb slave on a single 25 MHz clock
// Notes on behaviour
// - capture reads return the oldest fifo entry and pop it.
// - fifo empties on entering low power; host reads captures first.
// - counter write loads the running count for the current period only.
// - writing zero to the counter reloads it from the period.
// - period register is readable, writable, resolution wide, used as reload.
// - compare writes act at once; output follows on the next clock.
// - in dead-band mode every change of the first compare result restarts dead timing.
// - independent compare values for both outputs; the first serves both in dead-band mode.
// - 8-bit dead-time register holds dead-band counts minus one.
// - 8-bit kill-time register holds minimum killed counts.
// - control bit 7 enables; effect appears two clocks after the write.
// - fifo-full flag sets only when filling after a clear.
// - initialisation returns all registers, compare modes too, to defaults.
// - interrupt comes from status flags chosen by software mask.
// - period, dead-band, counter and control are readable and writable.
// - control bits 5:3 second compare mode, bits 2:0 first.
// - terminal count, compare and kill flags set on event, clear on read.
package pwri_pkg;
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_MASK     = 8'h08;
  localparam logic [7:0] ADDR_COUNTER  = 8'h0c;
  localparam logic [7:0] ADDR_PERIOD   = 8'h10;
  localparam logic [7:0] ADDR_CMP1     = 8'h14;
  localparam logic [7:0] ADDR_CMP2     = 8'h18;
  localparam logic [7:0] ADDR_DEADTIME = 8'h1c;
  localparam logic [7:0] ADDR_KILLTIME = 8'h20;
  localparam logic [7:0] ADDR_CAPTURE  = 8'h24;
  localparam logic [7:0] ADDR_AUX      = 8'h28;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_RESET_BIT  = 6;
  localparam int ST_CMP1  = 0;
  localparam int ST_CMP2  = 1;
  localparam int ST_TC    = 2;
  localparam int ST_FULL  = 3;
  localparam int ST_KILL  = 5;
  localparam int AUX_DEADBAND_BIT = 0;
  localparam int AUX_LOWPOWER_BIT = 1;
  localparam int AUX_FIFOCLR_BIT  = 2;
  localparam logic [2:0] CMP_LESS     = 3'h1;
  localparam logic [2:0] CMP_LESS_EQ  = 3'h2;
  localparam logic [2:0] CMP_EQUAL    = 3'h0;
  localparam logic [2:0] CMP_GREATER  = 3'h3;
  localparam logic [2:0] CMP_GREAT_EQ = 3'h4;
  localparam logic [7:0] RST_CONTROL  = 8'h09;
  localparam logic [5:0] RST_MASK     = 6'h04;
  localparam logic [15:0] RST_PERIOD  = 16'h00ff;
  localparam logic [15:0] RST_CMP1    = 16'h007f;
  localparam logic [15:0] RST_CMP2    = 16'h003f;
  localparam logic [7:0] RST_DEADTIME = 8'h00;
  localparam logic [7:0] RST_KILLTIME = 8'h00;
  localparam int ENABLE_DELAY_CYCLES = 2;
  typedef struct packed {
    logic        deadband_en;
    logic        kill_in;
    logic        capture_in;
  } pwri_hw_in_type;
  function automatic logic pwri_compare(input logic [2:0] mode,
                                        input logic [15:0] cnt,
                                        input logic [15:0] cmp);
    case (mode)
      CMP_LESS:     pwri_compare = cnt < cmp;
      CMP_LESS_EQ:  pwri_compare = cnt <= cmp;
      CMP_GREATER:  pwri_compare = cnt > cmp;
      CMP_GREAT_EQ: pwri_compare = cnt >= cmp;
      default:      pwri_compare = cnt == cmp;
    endcase
  endfunction
endpackage

// ==== rtl/pwri_capture_fifo.sv ====
// capture fifo: stores counter values, pops on read
// assumes push and pop come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pwri_capture_fifo
  import pwri_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clear,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head,
  output logic                  empty,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             do_push;
  logic             do_pop;
  assign empty   = wr_ptr == rd_ptr;
  assign full    = (wr_ptr[AW] != rd_ptr[AW]) &&
                   (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign do_pop  = pop && !empty;
  assign do_push = push && (!full || do_pop);
  assign head    = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem[wr_ptr[AW-1:0]] <= push_data;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (clear) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pwri_core.sv ====
// counter and compare core of the pwm
// assumes enable is already the delayed enable from the register side
`timescale 1ns/1ps
`default_nettype none
module pwri_core
  import pwri_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             enable,
  input  wire logic             soft_reset,
  input  wire logic             cnt_load,
  input  wire logic [WIDTH-1:0] cnt_value,
  input  wire logic [WIDTH-1:0] period,
  input  wire logic [WIDTH-1:0] cmp1,
  input  wire logic [WIDTH-1:0] cmp2,
  input  wire logic [2:0]       mode1,
  input  wire logic [2:0]       mode2,
  output logic      [WIDTH-1:0] count,
  output logic                  tc,
  output logic                  raw1,
  output logic                  raw2
);
  logic [15:0] cnt_wide;
  assign cnt_wide = 16'(count);
  assign tc = enable && (count == '0);
  // combinational compare so a new compare value acts at once
  assign raw1 = pwri_compare(mode1, cnt_wide, 16'(cmp1));
  assign raw2 = pwri_compare(mode2, cnt_wide, 16'(cmp2));
  // down counter reloading from period at terminal count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (soft_reset) begin
      count <= period;
    end else if (cnt_load) begin
      count <= (cnt_value == '0) ? period : cnt_value;
    end else if (enable) begin
      count <= (count == '0) ? period : count - 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pwri_top.sv ====
// apb register side of an 8/16-bit pwm with capture fifo and dead band
// assumes an apb master on pclk; capture, kill and low power are same-clock
`timescale 1ns/1ps
`default_nettype none
module pwri_top
  import pwri_pkg::*;
#(
  parameter int WIDTH      = 8,
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        capture_in,
  input  wire logic        kill_in,
  input  wire logic        sleep_req,
  output logic             pwm1,
  output logic             pwm2,
  output logic             irq
);
  initial begin
    if (WIDTH != 8 && WIDTH != 16)
      $error("width must be 8 or 16");
  end
  logic [7:0]       control;
  logic [5:0]       status;
  logic [5:0]       mask;
  logic [WIDTH-1:0] period;
  logic [WIDTH-1:0] cmp1;
  logic [WIDTH-1:0] cmp2;
  logic [7:0]       dead_time;
  logic [7:0]       kill_time;
  logic [2:0]       aux;
  logic             en_stage;
  logic             enable_eff;
  logic             armed;
  logic             cap_prev;
  logic             raw1;
  logic             raw2;
  logic             tc;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] fifo_head;
  logic             fifo_empty;
  logic             fifo_full;
  logic             raw1_q;
  logic             raw2_q;
  logic [7:0]       db_cnt;
  logic [8:0]       kill_cnt;
  logic             killed;
  logic             sleep_prev;
  logic             wr;
  logic             rd;
  logic             fifo_clear;
  logic             cnt_load;
  logic             cap_pop;
  logic [5:0]       events;
  logic [31:0]      next_prdata;
  assign wr  = psel && penable && pwrite;
  assign rd  = psel && penable && !pwrite;
  assign enable_eff = en_stage;
  assign cnt_load   = wr && (paddr == ADDR_COUNTER);
  assign cap_pop    = rd && (paddr == ADDR_CAPTURE);
  assign fifo_clear = (sleep_req && !sleep_prev) ||
                      (wr && paddr == ADDR_AUX &&
                       pwdata[AUX_FIFOCLR_BIT]);
  // registers, reset to their configured values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control   <= RST_CONTROL;
      mask      <= RST_MASK;
      period    <= RST_PERIOD[WIDTH-1:0];
      cmp1      <= RST_CMP1[WIDTH-1:0];
      cmp2      <= RST_CMP2[WIDTH-1:0];
      dead_time <= RST_DEADTIME;
      kill_time <= RST_KILLTIME;
      aux       <= '0;
    end else if (wr) begin
      case (paddr)
        ADDR_CONTROL:  control   <= pwdata[7:0];
        ADDR_MASK:     mask      <= pwdata[5:0];
        ADDR_PERIOD:   period    <= pwdata[WIDTH-1:0];
        ADDR_CMP1:     cmp1      <= pwdata[WIDTH-1:0];
        ADDR_CMP2:     cmp2      <= pwdata[WIDTH-1:0];
        ADDR_DEADTIME: dead_time <= pwdata[7:0];
        ADDR_KILLTIME: kill_time <= pwdata[7:0];
        ADDR_AUX:      aux       <= {1'b0, pwdata[1:0]};
        default: ;
      endcase
    end
  end
  // one stage here plus the output register make the two clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_stage <= 1'b0;
    end else begin
      en_stage <= control[CTRL_ENABLE_BIT];
    end
  end
  pwri_core #(
    .WIDTH (WIDTH)
  ) pwri_core_inst (
    .pclk       (pclk),
    .presetn    (presetn),
    .enable     (enable_eff),
    .soft_reset (control[CTRL_RESET_BIT]),
    .cnt_load   (cnt_load),
    .cnt_value  (pwdata[WIDTH-1:0]),
    .period     (period),
    .cmp1       (cmp1),
    .cmp2       (cmp2),
    .mode1      (control[2:0]),
    .mode2      (control[5:3]),
    .count      (count),
    .tc         (tc),
    .raw1       (raw1),
    .raw2       (raw2)
  );
  pwri_capture_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) pwri_capture_fifo_inst (
    .pclk      (pclk),
    .presetn   (presetn),
    .clear     (fifo_clear),
    .push      (enable_eff && capture_in && !cap_prev),
    .push_data (count),
    .pop       (cap_pop),
    .head      (fifo_head),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );
  // capture edge, sleep edge and full-flag arming
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_prev   <= 1'b0;
      sleep_prev <= 1'b0;
      armed      <= 1'b0;
    end else begin
      cap_prev   <= capture_in;
      sleep_prev <= sleep_req;
      if (fifo_clear) begin
        armed <= 1'b1;
      end
    end
  end
  // minimum-time kill hold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kill_cnt <= '0;
    end else if (kill_in) begin
      kill_cnt <= {1'b0, kill_time};
    end else if (kill_cnt != '0) begin
      kill_cnt <= kill_cnt - 1'b1;
    end
  end
  assign killed = kill_in || (kill_cnt != '0);
  // dead band timer restarts on any level change of the first compare result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw1_q <= 1'b0;
      raw2_q <= 1'b0;
      db_cnt <= '0;
    end else begin
      raw1_q <= raw1 && enable_eff;
      raw2_q <= raw2 && enable_eff;
      if (aux[AUX_DEADBAND_BIT] && ((raw1 && enable_eff) != raw1_q)) begin
        db_cnt <= dead_time;
      end else if (db_cnt != '0) begin
        db_cnt <= db_cnt - 1'b1;
      end
    end
  end
  // outputs registered: compare result shows one clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm1 <= 1'b0;
      pwm2 <= 1'b0;
    end else if (!enable_eff || killed) begin
      pwm1 <= 1'b0;
      pwm2 <= 1'b0;
    end else if (aux[AUX_DEADBAND_BIT]) begin
      pwm1 <= raw1 && (db_cnt == '0) && raw1_q;
      pwm2 <= !raw1 && (db_cnt == '0) && !raw1_q;
    end else begin
      pwm1 <= raw1;
      pwm2 <= raw2;
    end
  end
  assign events = {killed, 1'b0, 1'b0, tc,
                   raw2 && !raw2_q && enable_eff,
                   raw1 && !raw1_q && enable_eff};
  // status: sticky except the full bit, clear on read, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else begin
      // clear at the edge that latches prdata, so no event slips between
      if (psel && !penable && !pwrite && paddr == ADDR_STATUS) begin
        status <= events;
      end else begin
        status <= status | events;
      end
      status[ST_FULL] <= armed && fifo_full;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end
  always_comb begin
    next_prdata = '0;
    case (paddr)
      ADDR_CONTROL:  next_prdata[7:0] = control;
      ADDR_STATUS:   next_prdata[5:0] = status;
      ADDR_MASK:     next_prdata[5:0] = mask;
      ADDR_COUNTER:  next_prdata[WIDTH-1:0] = count;
      ADDR_PERIOD:   next_prdata[WIDTH-1:0] = period;
      ADDR_CMP1:     next_prdata[WIDTH-1:0] = cmp1;
      ADDR_CMP2:     next_prdata[WIDTH-1:0] = cmp2;
      ADDR_DEADTIME: next_prdata[7:0] = dead_time;
      ADDR_KILLTIME: next_prdata[7:0] = kill_time;
      ADDR_CAPTURE:  next_prdata[WIDTH-1:0] =
                       fifo_empty ? '0 : fifo_head;
      ADDR_AUX:      next_prdata[3:0] = {fifo_empty, aux};
      default:       next_prdata = '0;
    endcase
  end
  // apb answer: ready one cycle after setup, in the first cycle of the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && (paddr > ADDR_AUX || paddr[1:0] != 2'b00);
      if (psel && !penable) begin
        prdata <= next_prdata;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/pwri_top_properties.sv ====
// checker of pwri_top ports: apb timing, errors, irq mask, kill
// assumes binding into pwri_top on one pclk domain
`timescale 1ns/1ps
`default_nettype none
module pwri_top_checker
  import pwri_pkg::*;
#(
  parameter int WIDTH      = 8,
  parameter int FIFO_DEPTH = 4
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        capture_in,
  input wire logic        kill_in,
  input wire logic        sleep_req,
  input wire logic        pwm1,
  input wire logic        pwm2,
  input wire logic        irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad;
    psel && !penable && (paddr > ADDR_AUX || paddr[1:0] != 2'h0);
  endsequence
  sequence s_mask_off;
    psel && penable && pready && pwrite && paddr == ADDR_MASK
      && pwdata[5:0] == 6'h00;
  endsequence
  chk_ready_after_setup:
    assert property (s_setup |=> pready) else $error("no ready");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held");
  chk_ready_access:
    assert property (pready |-> psel && penable) else $error("stray ready");
  chk_err_bad_addr:
    assert property (s_bad |=> pslverr) else $error("no error");
  chk_err_good_addr:
    assert property (s_setup ##0 !(paddr > ADDR_AUX || paddr[1:0] != 2'h0)
      |=> !pslverr) else $error("false error");
  chk_err_read_zero:
    assert property (s_bad ##0 !pwrite |=> prdata == 32'h0)
      else $error("refused read data");
  chk_rdata_hold:
    assert property (!(psel && !penable) |=> $stable(prdata))
      else $error("read data moved");
  chk_irq_masked_off:
    assert property (s_mask_off |-> ##2 !irq) else $error("irq unmasked");
  chk_kill_outputs:
    assert property (kill_in [*2] |=> !pwm1 && !pwm2)
      else $error("kill ignored");
endmodule
bind pwri_top pwri_top_checker #(.WIDTH(WIDTH), .FIFO_DEPTH(FIFO_DEPTH))
  pwri_top_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .capture_in(capture_in), .kill_in(kill_in), .sleep_req(sleep_req),
  .pwm1(pwm1), .pwm2(pwm2), .irq(irq));
`default_nettype wire

// ==== dv/tb_pwri_top.sv ====
// bench for pwri_top: registers, counter, fifo, irq, enable, kill
// assumes the pwri_pkg map; drives every port at pclk rising edges
`timescale 1ns/1ps
`default_nettype none
module tb_pwri_top;
  import pwri_pkg::*;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [7:0]  paddr      = 8'h00;
  logic [31:0] pwdata     = 32'h0;
  logic        capture_in = 1'b0;
  logic        kill_in    = 1'b0;
  logic        sleep_req  = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwm1;
  logic        pwm2;
  logic        irq;
  logic [31:0] q;
  logic        er;
  logic [7:0]  v;
  int          k;
  int          err_total  = 0;
  int          n_tests    = 0;
  logic [7:0]  ra [9]     = '{ADDR_CONTROL, ADDR_MASK, ADDR_PERIOD, ADDR_CMP1,
    ADDR_CMP2, ADDR_DEADTIME, ADDR_KILLTIME, ADDR_STATUS, ADDR_AUX};
  logic [31:0] rv [9]     = '{32'h09, 32'h04, 32'hff, 32'h7f, 32'h3f, 32'h0,
    32'h0, 32'h0, 32'h08};
  always #20 pclk = ~pclk;
  pwri_top #(.WIDTH(8), .FIFO_DEPTH(4)) pwri_top_inst (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in(capture_in), .kill_in(kill_in),
    .sleep_req(sleep_req), .pwm1(pwm1), .pwm2(pwm2), .irq(irq));
  function automatic logic [31:0] cnt_exp(logic [7:0] w, logic [7:0] per);
    return (w == 8'h00) ? {24'h0, per} : {24'h0, w};
  endfunction
  task automatic give_verdict();
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    q  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk_word(q, exp);
  endtask
  task automatic pulse_capture(input int n);
    repeat (n) begin
      capture_in <= 1'b1;
      @(posedge pclk);
      capture_in <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  initial begin
    k = $urandom(32'h5d559ba7);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) rdc(ra[i], rv[i]);
    for (int i = 0; i < 24; i++) begin
      k = $urandom % 7;
      v = 8'($urandom);
      if (k == 0) v = {2'b00, 3'($urandom % 5), 3'($urandom % 5)};
      if (k == 1) v[7:6] = 2'b00;
      wr(ra[k], {24'h0, v});
      rdc(ra[k], {24'h0, v});
    end
    wr(ADDR_CONTROL, 32'h09);
    wr(ADDR_PERIOD, 32'h40);
    foreach (rv[i]) begin
      v = (i < 2) ? 8'h00 : 8'($urandom);
      wr(ADDR_COUNTER, {24'h0, v});
      rdc(ADDR_COUNTER, cnt_exp(v, 8'h40));
    end
    xfer(1'b0, 8'h2c, 32'h0);
    chk_bit(er, 1'b1);
    xfer(1'b1, 8'h12, 32'h0);
    chk_bit(er, 1'b1);
    rdc(ADDR_PERIOD, 32'h40);
    wr(ADDR_COUNTER, 32'h10);
    wr(ADDR_CMP1, 32'h7f);
    wr(ADDR_CONTROL, 32'h89);
    chk_bit(pwm1, 1'b0);
    @(posedge pclk);
    chk_bit(pwm1, 1'b0);
    @(posedge pclk);
    chk_bit(pwm1, 1'b1);
    wr(ADDR_CMP1, 32'h00);
    @(posedge pclk);
    chk_bit(pwm1, 1'b0);
    wr(ADDR_CMP1, 32'hff);
    @(posedge pclk);
    chk_bit(pwm1, 1'b1);
    wr(ADDR_CMP2, 32'h00);
    @(posedge pclk);
    chk_bit(pwm2, 1'b0);
    wr(ADDR_CMP2, 32'hff);
    @(posedge pclk);
    chk_bit(pwm2, 1'b1);
    wr(ADDR_DEADTIME, 32'h03);
    wr(ADDR_AUX, 32'h01);
    wr(ADDR_CMP1, 32'h00);
    repeat (4) begin
      @(posedge pclk);
      chk_bit(pwm1 | pwm2, 1'b0);
    end
    @(posedge pclk);
    chk_bit(pwm2, 1'b1);
    wr(ADDR_MASK, 32'h04);
    repeat (80) @(posedge pclk);
    chk_bit(irq, 1'b1);
    wr(ADDR_CONTROL, 32'h09);
    repeat (4) @(posedge pclk);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk_bit(q[ST_TC], 1'b1);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk_bit(q[ST_TC], 1'b0);
    chk_bit(irq, 1'b0);
    wr(ADDR_CONTROL, 32'h89);
    kill_in <= 1'b1;
    repeat (3) @(posedge pclk);
    kill_in <= 1'b0;
    @(posedge pclk);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk_bit(q[ST_KILL], 1'b1);
    wr(ADDR_MASK, 32'h00);
    wr(ADDR_AUX, 32'h04);
    wr(ADDR_COUNTER, 32'h3f);
    pulse_capture(4);
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk_bit(q[ST_FULL], 1'b1);
    for (int i = 0; i < 4; i++) begin
      rdc(ADDR_CAPTURE, 32'h3e - 32'(3 * i));
    end
    rdc(ADDR_CAPTURE, 32'h0);
    xfer(1'b0, ADDR_AUX, 32'h0);
    chk_bit(q[3], 1'b1);
    pulse_capture(2);
    sleep_req <= 1'b1;
    @(posedge pclk);
    sleep_req <= 1'b0;
    @(posedge pclk);
    rdc(ADDR_CAPTURE, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(ADDR_CONTROL, 32'h09);
    rdc(ADDR_PERIOD, 32'hff);
    give_verdict();
  end
endmodule
`default_nettype wire
